// file: hw/host_port_data_pin_mux.v
// What this block does
// R1: Strap low selects parallel I/O bits 43..36, high selects host data bus.
// R2: Selected function takes effect when reset is released.
// R3: In parallel I/O mode all eight lines are inputs after reset.
// R4: In host mode all eight data lines are inputs after reset.
// R5: Strap high gives multiplexed host mode, address and data share bus.
// R6: Each host cycle is two consecutive byte transfers, assembled here.
// R7: Bus holders keep the last driven level when pins float.
// R8: Holders enabled at reset, software control bit may change them.
// R9: Pins float in OFF mode: test reset 0, emu zero 1, emu off 0.
// R10: Pins float while reset is low.
// R11: Strap caught at reset release, held until next reset.

`include "host_port_data_pin_mux_defs.vh"

module host_port_data_pin_mux #(
  parameter WIDTH = `PIN_WIDTH
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_b,
  // Strap and test pins
  input  wire             i_boot_function_strap,
  input  wire             i_test_rst_b,
  input  wire             i_emulation_pin_zero,
  input  wire             i_emulation_off_pin,
  // Holder control from the external bus control register
  input  wire             i_holder_en,
  input  wire             i_holder_we,
  // Parallel I/O side
  input  wire [WIDTH-1:0] i_pio_out,
  input  wire [WIDTH-1:0] i_pio_dir,
  input  wire             i_pio_dir_we,
  output reg  [WIDTH-1:0] o_parallel_io_upper_bits,
  // Host interface side
  input  wire             i_host_strobe,
  input  wire             i_host_read,
  input  wire [WIDTH-1:0] i_host_rdata,
  output reg  [WIDTH-1:0] o_host_addr,
  output reg  [WIDTH-1:0] o_host_wdata,
  output reg              o_host_cycle_done,
  output reg              o_host_mode,
  output reg              o_holder_state,
  // Pads
  input  wire [WIDTH-1:0] i_host_port_data_pins,
  output wire [WIDTH-1:0] o_host_port_data_pins,
  output wire [WIDTH-1:0] o_host_port_data_pins_oe
);

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  // Capture one clock after release; async reset may only load constants
  reg strap_done_r;
  reg func_r;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_done_r <= 1'b0;
      func_r       <= `FUNC_PIO;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;                   // R2
      func_r       <= i_boot_function_strap;  // R11 R1 R5
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_host_mode <= 1'b0;
    end else begin
      o_host_mode <= strap_done_r ? func_r : i_boot_function_strap;
    end
  end

  // ****************************************************************
  // Holder and direction control
  // ****************************************************************
  reg             holder_r;
  reg [WIDTH-1:0] dir_r;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      holder_r <= `HOLDER_RESET;  // R8
      dir_r    <= `DIR_RESET;     // R3 R4
    end else begin
      if (i_holder_we) begin
        holder_r <= i_holder_en;  // R8
      end
      if (i_pio_dir_we && strap_done_r && func_r == `FUNC_PIO) begin
        dir_r <= i_pio_dir;       // R3
      end
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_holder_state <= `HOLDER_RESET;
    end else begin
      o_holder_state <= holder_r;
    end
  end

  wire off_mode;
  assign off_mode = !i_test_rst_b && i_emulation_pin_zero
                    && !i_emulation_off_pin;                  // R9

  // ****************************************************************
  // Multiplexed host cycle: address byte then data byte
  // ****************************************************************
  reg half_r;
  reg host_read_r;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      half_r            <= `HALF_ADDR;
      host_read_r       <= 1'b0;
      o_host_addr       <= 8'h00;
      o_host_wdata      <= 8'h00;
      o_host_cycle_done <= 1'b0;
    end else begin
      o_host_cycle_done <= 1'b0;
      if (strap_done_r && func_r == `FUNC_HOST && i_host_strobe) begin
        if (half_r == `HALF_ADDR) begin
          o_host_addr <= i_host_port_data_pins;  // R6
          host_read_r <= i_host_read;
          half_r      <= `HALF_DATA;
        end else begin
          if (!host_read_r) begin
            o_host_wdata <= i_host_port_data_pins;
          end
          half_r            <= `HALF_ADDR;        // R6
          o_host_cycle_done <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Pin drive selection
  // ****************************************************************
  reg [WIDTH-1:0] drive;
  reg [WIDTH-1:0] value;
  always @* begin
    drive = {WIDTH{1'b0}};
    value = {WIDTH{1'b0}};
    if (!strap_done_r || off_mode) begin
      drive = {WIDTH{1'b0}};                     // R9 R10
    end else if (func_r == `FUNC_PIO) begin
      drive = dir_r;
      value = i_pio_out;
    end else if (half_r == `HALF_DATA && host_read_r) begin
      drive = {WIDTH{1'b1}};
      value = i_host_rdata;
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_parallel_io_upper_bits <= 8'h00;
    end else begin
      o_parallel_io_upper_bits <= i_host_port_data_pins;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pad
      pin_pad_cell u_pad (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_drive     (drive[g]),
        .i_value     (value[g]),
        .i_holder_en (holder_r),
        .i_pad       (i_host_port_data_pins[g]),
        .o_pad       (o_host_port_data_pins[g]),
        .o_pad_oe    (o_host_port_data_pins_oe[g])
      );
    end
  endgenerate

endmodule

// file: hw/host_port_data_pin_mux_defs.vh
`ifndef HOST_PORT_DATA_PIN_MUX_DEFS_VH
`define HOST_PORT_DATA_PIN_MUX_DEFS_VH

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define PIN_WIDTH           8
`define PIO_LOW_BIT         36
`define PIO_HIGH_BIT        43
`define DIR_RESET           8'h00
`define HOLDER_RESET        1'b1
`define FUNC_PIO            1'b0
`define FUNC_HOST           1'b1
`define HALF_ADDR           1'b0
`define HALF_DATA           1'b1

`endif

// file: hw/pin_pad_cell.v
// ****************************************************************
// One pad slice: drive, float and bus holder
// ****************************************************************
module pin_pad_cell (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_b,
  // Control
  input  wire i_drive,
  input  wire i_value,
  input  wire i_holder_en,
  // Pad
  input  wire i_pad,
  output reg  o_pad,
  output reg  o_pad_oe
);

  reg last_r;

  // Remember the last driven level for the holder
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      last_r <= 1'b0;
    end else if (i_drive) begin
      last_r <= i_value;
    end
  end

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pad    <= 1'b0;
      o_pad_oe <= 1'b0;
    end else if (i_drive) begin
      o_pad    <= i_value;
      o_pad_oe <= 1'b1;
    end else if (i_holder_en) begin
      // Weak keeper: holds last level when floated
      o_pad    <= last_r; // R7
      o_pad_oe <= 1'b0;
    end else begin
      o_pad    <= 1'b0;
      o_pad_oe <= 1'b0;
    end
  end

  // Pad input is not used in this slice; it only feeds an unused wire
  wire unused_pad;
  assign unused_pad = i_pad;

endmodule

// file: verification/host_port_data_pin_mux_monitor.sv
// ***
// Pin mux checker
// ***
module pin_mux_monitor #(
  parameter WIDTH = 8
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_boot_function_strap,
  input wire i_test_rst_b,
  input wire i_emulation_pin_zero,
  input wire i_emulation_off_pin,
  input wire i_holder_en,
  input wire i_holder_we,
  input wire i_host_strobe,
  input wire [WIDTH-1:0] i_host_port_data_pins,
  input wire [WIDTH-1:0] o_host_addr,
  input wire o_host_cycle_done,
  input wire o_host_mode,
  input wire o_holder_state,
  input wire [WIDTH-1:0] o_host_port_data_pins,
  input wire [WIDTH-1:0] o_host_port_data_pins_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire [WIDTH-1:0] oe_w = o_host_port_data_pins_oe;
  wire [WIDTH-1:0] q_w = o_host_port_data_pins;
  wire stb_w = i_host_strobe && o_host_mode;
  // Next byte half; strobes outside host mode do not count
  logic half_r;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b)
      half_r <= 1'b0;
    else if (stb_w)
      half_r <= ~half_r;
  end
  a_float_in_reset: assert property (disable iff (1'b0)
    !i_rst_b |-> oe_w == '0) else $error("pads driven in reset");
  a_mode_from_strap: assert property (
    $rose(i_rst_b) |=> o_host_mode == $past(i_boot_function_strap))
    else $error("mode not strap");
  a_mode_held: assert property (
    $changed(o_host_mode) |-> !$past(i_rst_b, 2)) else $error("mode moved");
  a_off_floats: assert property (
    !i_test_rst_b && i_emulation_pin_zero && !i_emulation_off_pin
    |=> oe_w == '0) else $error("pads driven in off mode");
  a_addr_capture: assert property (
    stb_w && !half_r |=> o_host_addr == $past(i_host_port_data_pins))
    else $error("address byte lost");
  a_cycle_done: assert property (
    o_host_cycle_done == $past(stb_w && half_r)) else $error("done wrong");
  a_holder_keep: assert property (
    o_holder_state && oe_w == '0 && $past(oe_w) == '1 |-> q_w == $past(q_w))
    else $error("holder lost level");
  // Holder bit lands one edge after the write, its copy one edge later
  a_holder_write: assert property (
    i_holder_we |-> ##2 o_holder_state == $past(i_holder_en, 2))
    else $error("holder bit not written");
  c_cycle: cover property (o_host_cycle_done);
  c_read: cover property (oe_w == '1);
  c_holder: cover property ($fell(o_holder_state));
endmodule

bind host_port_data_pin_mux pin_mux_monitor #(.WIDTH(WIDTH)) u_mon (
  .i_clk, .i_rst_b, .i_boot_function_strap, .i_test_rst_b,
  .i_emulation_pin_zero, .i_emulation_off_pin, .i_holder_en, .i_holder_we,
  .i_host_strobe, .i_host_port_data_pins, .o_host_addr, .o_host_cycle_done,
  .o_host_mode, .o_holder_state, .o_host_port_data_pins,
  .o_host_port_data_pins_oe);

// file: verification/host_model.sv
// ***
// Host processor on the shared byte bus
// ***
module host_model (
  input wire logic i_clk,
  input wire logic i_keep,
  input wire logic [7:0] i_dev_q,
  input wire logic [7:0] i_dev_oe,
  output logic o_stb = 1'b0,
  output logic o_rd = 1'b0,
  output wire logic [7:0] o_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic en = 1'b0;
  logic [7:0] drv = 8'h00;
  // Undriven, unkept lines show the inverse, never a stale copy
  assign o_pins = (i_dev_oe & i_dev_q)
    | (~i_dev_oe & (en ? drv : (i_keep ? i_dev_q : ~drv)));
  task put(input logic e, input logic [7:0] v);
    en = e;
    drv = v;
  endtask
  task cycle(input logic r, input logic [7:0] a, d, input int gap,
             output logic [7:0] q);
    @(negedge i_clk);
    put(1'b1, a);
    o_rd = r;
    o_stb = 1'b1;
    repeat (gap) begin
      @(negedge i_clk);
      o_stb = 1'b0;
      en = 1'b0;
    end
    @(negedge i_clk);
    put(!r, d);
    q = o_pins;
    o_stb = 1'b1;
    @(negedge i_clk);
    o_stb = 1'b0;
    en = 1'b0;
  endtask
endmodule

// file: verification/test_host_port_data_pin_mux.sv
// ***
// Pin mux bench
// ***
module test_host_port_data_pin_mux;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic strap = 1'b0;
  // Test reset, emulation zero, emulation off
  logic [2:0] offp = 3'b101;
  logic hen = 1'b1, hwe = 1'b0, dwe = 1'b0;
  logic [7:0] pout = 8'hA5, pdir = 8'h0F, rdat = 8'h5A, q;
  wire stb, rd, done, mode, hst;
  wire [7:0] pin, pio, addr, wdat, pq, poe;
  int err_total = 0;
  int samples_checked = 0;
  host_port_data_pin_mux DUT (
    .i_clk(clk), .i_rst_b(rst_b), .i_boot_function_strap(strap),
    .i_test_rst_b(offp[2]), .i_emulation_pin_zero(offp[1]),
    .i_emulation_off_pin(offp[0]), .i_holder_en(hen), .i_holder_we(hwe),
    .i_pio_out(pout), .i_pio_dir(pdir), .i_pio_dir_we(dwe),
    .o_parallel_io_upper_bits(pio), .i_host_strobe(stb), .i_host_read(rd),
    .i_host_rdata(rdat), .o_host_addr(addr), .o_host_wdata(wdat),
    .o_host_cycle_done(done), .o_host_mode(mode), .o_holder_state(hst),
    .i_host_port_data_pins(pin), .o_host_port_data_pins(pq),
    .o_host_port_data_pins_oe(poe));
  host_model host (.i_clk(clk), .i_keep(hst), .i_dev_q(pq), .i_dev_oe(poe),
    .o_stb(stb), .o_rd(rd), .o_pins(pin));
  task chk(input string n, input logic [7:0] e, s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task go(input int n);
    repeat (n) @(negedge clk);
  endtask
  task reset_to(input logic s);
    go(1);
    rst_b = 1'b0;
    strap = s;
    go(16);
    chk("pads in reset", 8'h00, poe);
    chk("holder", 8'h01, {7'h00, hst});
    rst_b = 1'b1;
    go(2);
    chk("mode", {7'h00, s}, {7'h00, mode});
    chk("pads", 8'h00, poe);
  endtask
  task t_pio;
    reset_to(1'b0);
    host.put(1'b1, 8'h96);
    go(3);
    chk("pio in", 8'h96, pio);
    host.put(1'b0, 8'h96);
    dwe = 1'b1;
    go(1);
    dwe = 1'b0;
    go(2);
    chk("dir", 8'h0F, poe);
    chk("pio out", 8'h05, pq & 8'h0F);
    offp = 3'b010;
    go(2);
    chk("off", 8'h00, poe);
    offp = 3'b101;
  endtask
  task t_host;
    reset_to(1'b1);
    strap = 1'b0;
    host.cycle(1'b0, 8'h3C, 8'hC3, 0, q);
    chk("addr", 8'h3C, addr);
    chk("wdata", 8'hC3, wdat);
    chk("done", 8'h01, {7'h00, done});
    chk("mode held", 8'h01, {7'h00, mode});
    host.cycle(1'b1, 8'h81, 8'h00, 3, q);
    chk("rdata", 8'h5A, q);
    go(2);
    chk("kept", 8'h5A, pq);
    hen = 1'b0;
    hwe = 1'b1;
    go(1);
    hwe = 1'b0;
    go(1);
    chk("holder", 8'h00, {7'h00, hst});
  endtask
  initial forever #12.5 clk = ~clk;
  initial begin
    #(25 * 1000);
    err_total++;
    wrap_up;
  end
  initial begin
    t_pio;
    t_host;
    wrap_up;
  end
endmodule
